// file: sasq_pkg.sv
/*
 * Constants for the SAR converter sequencer: register indices, field
 * positions, reset values and phase timing.
 * Assumes a 250 MHz system clock and an AHB-Lite word bus.
 */
package sasq_pkg;
    // Register indices; byte address is four times the index
    localparam logic [11:0] SASQ_IDX_CTL = 12'hF70;
    localparam logic [11:0] SASQ_IDX_RHI = 12'hF72;
    localparam logic [11:0] SASQ_IDX_RLO = 12'hF73;
    localparam logic [11:0] SASQ_IDX_SST = 12'hF74;
    localparam logic [11:0] SASQ_IDX_SMP = 12'hF75;
    // Control register fields
    localparam int SASQ_CTL_START = 7;
    localparam int SASQ_CTL_INTERNAL_REF_ENABLE = 5;
    localparam int SASQ_CTL_EN = 4;
    localparam int SASQ_SEL_W = 3;
    localparam int SASQ_SST_W = 4;
    localparam int SASQ_SMP_W = 6;
    localparam int SASQ_RES_W = 10;
    localparam int SASQ_LOW_W = 2;
    localparam int SASQ_LOW_POS = 6;
    // Reset values
    localparam logic [7:0] SASQ_CTL_RST = 8'h00;
    localparam logic [SASQ_SST_W-1:0] SASQ_SST_RST = 4'hF;
    localparam logic [SASQ_SMP_W-1:0] SASQ_SMP_RST = 6'h3F;
    // Conversion clock and phase timing
    localparam int SASQ_DIV_W = 4;
    localparam logic [SASQ_DIV_W-1:0] SASQ_DIV_LAST = 4'hF;
    localparam logic [3:0] SASQ_CONV_LAST = 4'hC;
    localparam logic [3:0] SASQ_LAST_BIT_TICK = 4'h9;
    localparam logic [SASQ_RES_W-1:0] SASQ_SAR_MSB = 10'h200;
    localparam int SASQ_CLK_PS = 4000;
    localparam int SASQ_MIN_SAMPLE_NS = 1000;
    localparam int SASQ_MIN_SETTLE_NS = 500;
    localparam int SASQ_MIN_SAMPLE_CYC =
        (SASQ_MIN_SAMPLE_NS * 1000 + SASQ_CLK_PS - 1) / SASQ_CLK_PS;
    localparam int SASQ_MIN_SETTLE_CYC =
        (SASQ_MIN_SETTLE_NS * 1000 + SASQ_CLK_PS - 1) / SASQ_CLK_PS;
    // Sequencer states
    typedef enum logic [1:0] {
        SASQ_IDLE = 2'b00,
        SASQ_SAMPLE = 2'b01,
        SASQ_SETTLE = 2'b10,
        SASQ_CONV = 2'b11
    } sasq_state_t;
endpackage

// file: sasq_top.sv
/*
 * SAR converter sequencer: AHB-Lite register slave, sample/settle/convert
 * sequencer, successive-approximation search and result registers.
 * Assumes an external comparator, DAC and analog mux, and an interrupt
 * controller that clears the completion request with a pulse.
 */
// The implementer's own choice: the AHB-Lite register port.
// Notes on behaviour
// - Result is 1024 times input over reference, saturating both ends.
// - Writing one to start bit launches conversion on selected input.
// - Writing zero to start does nothing; reading zero means idle.
// - Start bit reads one throughout a running conversion.
// - Start during conversion aborts it and restarts from sampling; a start in its last cycle still stores the result and raises the request.
// - Each measurement begins with a programmable sampling phase.
// - A programmable settling phase follows sampling before conversion.
// - Conversion phase lasts exactly thirteen conversion clock cycles.
// - Completion of each conversion raises an interrupt request.
// - Disabling the converter leaves a pending request in place.
// - Reference enable bit picks internal or external reference.
// - Enable bit zero puts converter into low-power disabled state.
// - Three-bit select field value n picks analog input n.
// - High-byte register is read-only, upper eight result bits.
// - Reading the high byte latches the low two bits coherently.
// - Results change only when a conversion completes.
// - Low register bits 7 and 6 hold the two result LSBs.
// - Settling length equals the four-bit settle count in clocks; a count of zero gives one clock.
// - Sampling length equals the sample count field in clocks; a count of zero gives one clock.
`timescale 1ns/1ns
module sasq_top
    import sasq_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Analog front end
    input wire logic comp_i,
    output logic [SASQ_SEL_W-1:0] input_select_o,
    output logic internal_ref_enable_o,
    output logic converter_enable_o,
    output logic sample_o,
    output logic [SASQ_RES_W-1:0] sar_code_o,
    // Completion request
    input wire logic irq_clear_i,
    output logic conv_done_irq_o
);

////////////////////////////////////////////////////////////////////////////
    logic wr_ph_q;
    logic rd_ph_q;
    logic [11:0] idx_q;
    logic [31:0] hrdata_q;
    logic start_q;
    logic internal_ref_enable_q;
    logic en_q;
    logic [SASQ_SEL_W-1:0] sel_q;
    logic [SASQ_SST_W-1:0] sst_q;
    logic [SASQ_SMP_W-1:0] smp_q;
    logic [SASQ_RES_W-1:0] res_q;
    logic [SASQ_LOW_W-1:0] low_q;
    logic [SASQ_RES_W-1:0] sar_q;
    logic irq_q;
    sasq_state_t state_q;
    logic [SASQ_SMP_W-1:0] cnt_q;
    logic [SASQ_DIV_W-1:0] div_q;
    logic [3:0] tick_q;
    logic addr_ok;
    logic ctl_wr;
    logic stop;
    logic go;
    logic tick;
    logic done;
    logic [7:0] rd_mux;

    // Phase counts of zero still take one clock
    function automatic logic last_cnt(input logic [SASQ_SMP_W-1:0] c);
        last_cnt = (c <= {{(SASQ_SMP_W-1){1'b0}}, 1'b1});
    endfunction

////////////////////////////////////////////////////////////////////////////
    // Bus slave: writes have no wait, reads take one wait state so the
    // read data comes from a flop yet sees a write just before it.
    assign addr_ok = hsel_i & htrans_i[1] & hready_i;
    assign hreadyout_o = ~rd_ph_q;
    assign hresp_o = 1'b0;
    assign hrdata_o = hrdata_q;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ph_q <= 1'b0;
            rd_ph_q <= 1'b0;
            idx_q <= 12'h000;
        end else begin
            wr_ph_q <= addr_ok & hwrite_i;
            rd_ph_q <= addr_ok & ~hwrite_i;
            if (addr_ok) begin
                idx_q <= haddr_i[13:2];
            end
        end
    end

    always_comb begin
        rd_mux = 8'h00;
        unique case (idx_q)
            SASQ_IDX_CTL: begin
                rd_mux[SASQ_CTL_START] = start_q;
                rd_mux[SASQ_CTL_INTERNAL_REF_ENABLE] = internal_ref_enable_q;
                rd_mux[SASQ_CTL_EN] = en_q;
                rd_mux[SASQ_SEL_W-1:0] = sel_q;
            end
            SASQ_IDX_RHI: rd_mux = res_q[SASQ_RES_W-1:SASQ_LOW_W];
            SASQ_IDX_RLO: rd_mux[7:SASQ_LOW_POS] = low_q;
            SASQ_IDX_SST: rd_mux[SASQ_SST_W-1:0] = sst_q;
            SASQ_IDX_SMP: rd_mux[SASQ_SMP_W-1:0] = smp_q;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hrdata_q <= 32'h0000_0000;
        end else if (rd_ph_q) begin
            hrdata_q <= {24'h00_0000, rd_mux};
        end
    end

    // Low bits are caught on the high-byte read so both halves match
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            low_q <= 2'h0;
        end else if (rd_ph_q && idx_q == SASQ_IDX_RHI) begin
            low_q <= res_q[SASQ_LOW_W-1:0];
        end
    end

////////////////////////////////////////////////////////////////////////////
    // Configuration registers; reserved bits are not stored
    assign ctl_wr = wr_ph_q && idx_q == SASQ_IDX_CTL;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            internal_ref_enable_q <= SASQ_CTL_RST[SASQ_CTL_INTERNAL_REF_ENABLE];
            en_q <= SASQ_CTL_RST[SASQ_CTL_EN];
            sel_q <= SASQ_CTL_RST[SASQ_SEL_W-1:0];
        end else if (ctl_wr) begin
            internal_ref_enable_q <= hwdata_i[SASQ_CTL_INTERNAL_REF_ENABLE];
            en_q <= hwdata_i[SASQ_CTL_EN];
            sel_q <= hwdata_i[SASQ_SEL_W-1:0];
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sst_q <= SASQ_SST_RST;
            smp_q <= SASQ_SMP_RST;
        end else if (wr_ph_q) begin
            if (idx_q == SASQ_IDX_SST) begin
                sst_q <= hwdata_i[SASQ_SST_W-1:0];
            end
            if (idx_q == SASQ_IDX_SMP) begin
                smp_q <= hwdata_i[SASQ_SMP_W-1:0];
            end
        end
    end

    assign internal_ref_enable_o = internal_ref_enable_q;
    assign converter_enable_o = en_q;
    assign input_select_o = sel_q;

////////////////////////////////////////////////////////////////////////////
    // Sequencer: enable travels with the start write, so one write may
    // both enable and start; a zero start bit is simply not looked at.
    assign go = ctl_wr & hwdata_i[SASQ_CTL_START]
        & hwdata_i[SASQ_CTL_EN];
    // Clearing enable aborts on the write itself, so busy drops at once
    // and a completion landing in that same cycle is dropped with it
    assign stop = ctl_wr & ~hwdata_i[SASQ_CTL_EN];
    assign tick = div_q == SASQ_DIV_LAST;
    assign done = state_q == SASQ_CONV && tick && tick_q == SASQ_CONV_LAST
        && !stop;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= SASQ_IDLE;
            cnt_q <= '0;
        end else if (go) begin
            state_q <= SASQ_SAMPLE;
            cnt_q <= smp_q;
        end else if (!en_q || stop) begin
            state_q <= SASQ_IDLE;
        end else begin
            unique case (state_q)
                SASQ_IDLE: state_q <= SASQ_IDLE;
                SASQ_SAMPLE: begin
                    if (last_cnt(cnt_q)) begin
                        state_q <= SASQ_SETTLE;
                        cnt_q <= {{(SASQ_SMP_W-SASQ_SST_W){1'b0}}, sst_q};
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                SASQ_SETTLE: begin
                    if (last_cnt(cnt_q)) begin
                        state_q <= SASQ_CONV;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                SASQ_CONV: begin
                    if (done) begin
                        state_q <= SASQ_IDLE;
                    end
                end
            endcase
        end
    end

    assign start_q = state_q != SASQ_IDLE;
    assign sample_o = state_q == SASQ_SAMPLE;

    // Divider and tick count restart on entry so every conversion
    // spans exactly thirteen full divided periods
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= '0;
            tick_q <= 4'h0;
        end else if (state_q != SASQ_CONV) begin
            div_q <= '0;
            tick_q <= 4'h0;
        end else begin
            div_q <= div_q + 1'b1;
            if (tick) begin
                tick_q <= tick_q + 4'h1;
            end
        end
    end

    // Binary search, MSB first, one bit per conversion clock; inputs past
    // either rail simply keep all bits or drop all bits
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sar_q <= '0;
        end else if (state_q != SASQ_CONV) begin
            sar_q <= SASQ_SAR_MSB;
        end else if (tick && tick_q <= SASQ_LAST_BIT_TICK) begin
            sar_q[SASQ_LAST_BIT_TICK - tick_q] <= comp_i;
            if (tick_q != SASQ_LAST_BIT_TICK) begin
                sar_q[SASQ_LAST_BIT_TICK - tick_q - 4'h1] <= 1'b1;
            end
        end
    end

    assign sar_code_o = sar_q;

////////////////////////////////////////////////////////////////////////////
    // Results and completion request
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            res_q <= '0;
        end else if (done) begin
            res_q <= sar_q;
        end
    end

    // Set beats clear; enable is not looked at here
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else if (done) begin
            irq_q <= 1'b1;
        end else if (irq_clear_i) begin
            irq_q <= 1'b0;
        end
    end

    assign conv_done_irq_o = irq_q;

////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [7:0] ph_len_q;
    logic ph_end;

    // High in the last cycle of a phase, so the count holds the length of
    // the running phase including the present cycle
    assign ph_end = go || stop || !en_q || done
        || (state_q == SASQ_SAMPLE && last_cnt(cnt_q))
        || (state_q == SASQ_SETTLE && last_cnt(cnt_q));

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ph_len_q <= 8'h00;
        end else if (ph_end) begin
            ph_len_q <= 8'h01;
        end else if (ph_len_q != 8'hFF) begin
            ph_len_q <= ph_len_q + 8'h01;
        end
    end

    AST_START_GO: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        go |=> state_q == SASQ_SAMPLE && start_q && cnt_q == $past(smp_q))
        else $error("start write did not launch sampling");

    AST_ZERO_START: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ctl_wr && !hwdata_i[SASQ_CTL_START] && state_q == SASQ_IDLE
        |=> state_q == SASQ_IDLE)
        else $error("zero start bit changed state");

    AST_DISABLED_START: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        ctl_wr && !hwdata_i[SASQ_CTL_EN] |=> !start_q && $stable(res_q))
        else $error("start accepted while disabled");

    AST_ABORT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        go && state_q == SASQ_CONV |=> state_q == SASQ_SAMPLE
        ##1 $stable(res_q))
        else $error("restart did not abort conversion");

    AST_SAMPLE_LEN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        state_q == SASQ_SAMPLE && !go ##1 state_q == SASQ_SETTLE
        |-> $past(ph_len_q) == ((smp_q > 6'h01) ? {2'b00, smp_q} : 8'h01))
        else $error("sampling length wrong");

    AST_SETTLE_LEN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        state_q == SASQ_SETTLE && !go ##1 state_q == SASQ_CONV
        |-> $past(ph_len_q) == ((sst_q > 4'h1) ? {4'h0, sst_q} : 8'h01))
        else $error("settling length wrong");

    AST_CONV_LEN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        done |-> ph_len_q == 8'hD0)
        else $error("conversion not thirteen divided clocks");

    AST_DONE_UPDATE: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        done && !go |=> !start_q && irq_q && res_q == $past(sar_q))
        else $error("completion effects not together");

    AST_IRQ_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        irq_q && !irq_clear_i |=> irq_q)
        else $error("pending request lost");

    AST_RESULT_STABLE: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        !done |=> $stable(res_q))
        else $error("result changed without completion");

    AST_LOW_LATCH: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        rd_ph_q && idx_q == SASQ_IDX_RHI
        |=> low_q == $past(res_q[SASQ_LOW_W-1:0])
        && hrdata_q[7:0] == $past(res_q[SASQ_RES_W-1:SASQ_LOW_W]))
        else $error("high read did not latch low bits");

endmodule

// file: test_sar_adc_sequencer.sv
/*
 * Self-checking bench for the SAR converter sequencer: an AHB-Lite master,
 * an ideal comparator and a bench model of results and phase timing.
 * Assumes sasq_pkg and sasq_top are compiled first; one slave on the bus.
 */
`timescale 1ns/1ns
module test_sar_adc_sequencer
    import sasq_pkg::*;
;
    localparam logic [31:0] A_CTL = {18'h0, SASQ_IDX_CTL, 2'h0};
    localparam logic [31:0] A_RHI = {18'h0, SASQ_IDX_RHI, 2'h0};
    localparam logic [31:0] A_RLO = {18'h0, SASQ_IDX_RLO, 2'h0};
    localparam logic [31:0] A_SST = {18'h0, SASQ_IDX_SST, 2'h0};
    localparam logic [31:0] A_SMP = {18'h0, SASQ_IDX_SMP, 2'h0};
    localparam logic [31:0] A_BAD = 32'h00003DE0;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic irq_clr = 1'b0;
    logic [9:0] vin = 10'h0;
    logic [31:0] seed = 32'hBEACE274;
    logic [31:0] hrdata;
    logic hready, hresp, sample, ref_en, conv_en, irq, comp;
    logic [2:0] sel;
    logic [9:0] code;
    int n_errors = 0;
    int compares = 0;

    ////////////////////////////////////////////////////////////////////////
    // Ideal comparator: the search should land exactly on vin
    assign comp = (vin >= code);
    always #2 clk = ~clk;

    sasq_top sasq_top_i (.ref_clk_i(clk), .rst_i(rst), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .comp_i(comp), .input_select_o(sel), .internal_ref_enable_o(ref_en),
        .converter_enable_o(conv_en), .sample_o(sample), .sar_code_o(code),
        .irq_clear_i(irq_clr), .conv_done_irq_o(irq));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50) begin
                n_errors++;
                stop_test();
            end
            @(posedge clk);
        end
    endtask

    // Single word transfer; caller stands just after a rising edge
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask

    // Counts edges from the start write until the request shows
    task automatic wait_done(output int n, output int ns);
        n = 0;
        ns = 0;
        while (irq !== 1'b1) begin
            @(posedge clk);
            n++;
            if (sample === 1'b1) ns++;
            if (n > 2000) begin
                n_errors++;
                stop_test();
            end
        end
    endtask

    task automatic clr_irq();
        irq_clr <= 1'b1;
        @(posedge clk);
        irq_clr <= 1'b0;
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        logic [9:0] v;
        logic [9:0] v2;
        int n, ns, s, m, sx, mx;
        int svals[3] = '{0, 5, 63};
        int mvals[3] = '{0, 3, 15};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(A_CTL, 32'h0);
        rd_chk(A_SST, 32'h0F);
        rd_chk(A_SMP, 32'h3F);
        wr(A_RHI, 32'hFF);
        rd_chk(A_RHI, 32'h0);
        rd_chk(A_RLO, 32'h0);
        wr(A_BAD, 32'hFF);
        rd_chk(A_BAD, 32'h0);
        chk({31'h0, conv_en}, 32'h0);
        // Phase lengths at both ends of the fields, results at both rails
        for (int i = 0; i < 3; i++) begin
            r = rnd();
            s = svals[i];
            m = mvals[i];
            sx = (s == 0) ? 1 : s;
            mx = (m == 0) ? 1 : m;
            v = (i == 0) ? 10'h0 : (i == 1) ? 10'h3FF : r[13:4];
            vin <= v;
            wr(A_SMP, s);
            wr(A_SST, m);
            // Reserved control bits always written as zero
            wr(A_CTL, {24'h0, 2'b10, r[3], 2'b10, r[2:0]});
            wait_done(n, ns);
            chk(n, sx + mx + 209);
            chk(ns, sx);
            chk({29'h0, sel}, {29'h0, r[2:0]});
            chk({31'h0, ref_en}, {31'h0, r[3]});
            chk({31'h0, conv_en}, 32'h1);
            rd_chk(A_CTL, {24'h0, 2'b00, r[3], 2'b10, r[2:0]});
            rd_chk(A_RHI, {24'h0, v[9:2]});
            rd_chk(A_RLO, {24'h0, v[1:0], 6'h0});
            clr_irq();
        end
        // Restart in mid-run; old result stays until completion
        r = rnd();
        v2 = r[9:0];
        vin <= v2;
        wr(A_CTL, 32'h91);
        rd_chk(A_CTL, 32'h91);
        // Let the first run reach its conversion phase before the restart
        repeat (100) @(posedge clk);
        rd_chk(A_RHI, {24'h0, v[9:2]});
        v2 = ~r[9:0];
        vin <= v2;
        wr(A_CTL, 32'h91);
        wait_done(n, ns);
        chk(n, 63 + 15 + 209);
        rd_chk(A_RLO, {24'h0, v[1:0], 6'h0});
        rd_chk(A_RHI, {24'h0, v2[9:2]});
        rd_chk(A_RLO, {24'h0, v2[1:0], 6'h0});
        // Disable with a request pending, then start while disabled
        wr(A_CTL, 32'h0);
        rd_chk(A_CTL, 32'h0);
        chk({31'h0, irq}, 32'h1);
        chk({31'h0, conv_en}, 32'h0);
        wr(A_CTL, 32'h80);
        rd_chk(A_CTL, 32'h0);
        rd_chk(A_RHI, {24'h0, v2[9:2]});
        wr(A_CTL, 32'h10);
        rd_chk(A_CTL, 32'h10);
        // Zero start leaves a run going; clearing enable aborts it
        wr(A_CTL, 32'h90);
        wr(A_CTL, 32'h10);
        rd_chk(A_CTL, 32'h90);
        wr(A_CTL, 32'h0);
        rd_chk(A_CTL, 32'h0);
        rd_chk(A_RHI, {24'h0, v2[9:2]});
        chk({31'h0, irq}, 32'h1);
        clr_irq();
        stop_test();
    end
endmodule
